// >>> hdl/ospm_clk_div.sv
`include "ospm_consts.svh"

// Enable generator: one-cycle pulse every div_i cycles while run_i
module ospm_clk_div
    import ospm_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  run_i,
    input  wire logic [`OSPM_DIV_W-1:0] div_i,
    output logic                       tick_o
);

    logic [`OSPM_DIV_W-1:0] count;   // Cycles since last tick

    // Counter wraps at div_i; cleared when stopped so restart is clean
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (count + 1'b1 >= div_i) begin
            count  <= '0;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule

// >>> hdl/ospm_ctrl.sv
`include "ospm_consts.svh"

module ospm_ctrl
    import ospm_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // CPU side
    input  wire logic        halt_i,
    input  wire logic        wake_i,
    output logic             cpu_run_o,
    output logic             cpu_sys_clk_o,
    // Clock enables for peripherals, then the current mode
    output logic             high_clk_o,
    output logic             sub_clk_o,
    output logic             slow_rc_clk_o,
    output logic             wdt_clk_o,
    output logic             tbase_clk_o,
    output logic [5:0]       mode_o
);

    // Control registers
    logic [2:0]  sys_clk_sel;        // System clock select
    logic        hs_osc_halt_keep;   // Keep fast oscillator in halt
    logic        ls_osc_halt_keep;   // Keep sub clock in halt
    logic [1:0]  fast_rc_freq_sel;   // Requested fast frequency
    logic [1:0]  freq_active;        // Frequency actually running
    logic        fast_rc_enable;     // Fast oscillator enable
    logic        fast_rc_stable;     // Fast oscillator settled
    logic [`OSPM_CNT_W-1:0] settle_cnt;  // Settling timer
    ospm_mode_t  mode;               // Current power mode
    ospm_mode_t  next_mode;          // Mode decode result
    logic        answered;           // Bus answer phase
    logic        req;                // Bus request pending

    // Oscillator tick enables
    logic        fast_run;
    logic        fast_tick;
    logic        slow_tick;
    logic        sub_run;
    logic [`OSPM_DIV_W-1:0] fast_div;
    logic [`OSPM_DIV_W-1:0] sys_div;
    logic [6:0]  presc;              // high_clk prescaler for /2../64
    logic        sys_tick;           // Chosen CPU clock tick
    logic        wr_scc;
    logic        wr_frc;

    // Decode frequency code to reference divide ratio
    function automatic logic [`OSPM_DIV_W-1:0] freq_div(input logic [1:0] code);
        case (code)
            `OSPM_FREQ_4M: freq_div = `OSPM_DIV_W'(`OSPM_CLK_HZ / `OSPM_F4M_HZ);
            `OSPM_FREQ_8M: freq_div = `OSPM_DIV_W'(`OSPM_CLK_HZ / `OSPM_F8M_HZ);
            default:       freq_div = `OSPM_DIV_W'(`OSPM_CLK_HZ / `OSPM_F2M_HZ);
        endcase
    endfunction

    // Single-cycle wait so the answer lands one edge after the request
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~answered;
    assign wr_scc = avs_write & answered & (avs_address == `OSPM_OFS_SYS_CLK_CTRL) & avs_byteenable[0];
    assign wr_frc = avs_write & answered & (avs_address == `OSPM_OFS_FAST_RC_CTRL) & avs_byteenable[0];

    // Answer phase toggles so each request sees one wait cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            answered <= 1'b0;
        end else begin
            answered <= req & ~answered;
        end
    end

    // System clock control: selection and halt keep bits
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_clk_sel      <= 3'(`OSPM_SCC_RESET >> `OSPM_SCC_SEL_LO);
            hs_osc_halt_keep <= 1'b0;
            ls_osc_halt_keep <= 1'b0;
        end else if (wr_scc) begin
            sys_clk_sel      <= avs_writedata[`OSPM_SCC_SEL_HI:`OSPM_SCC_SEL_LO];
            hs_osc_halt_keep <= avs_writedata[`OSPM_SCC_HS_KEEP];
            ls_osc_halt_keep <= avs_writedata[`OSPM_SCC_LS_KEEP];
        end
    end

    // Fast RC control: enable and frequency request
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_rc_enable   <= `OSPM_FRC_EN_RESET;
            fast_rc_freq_sel <= `OSPM_FRC_SEL_RESET;
        end else if (wr_frc) begin
            fast_rc_enable   <= avs_writedata[`OSPM_FRC_ENABLE];
            fast_rc_freq_sel <= avs_writedata[`OSPM_FRC_FREQ_HI:`OSPM_FRC_FREQ_LO];
        end
    end

    // Settling: flag drops on disable or frequency change, rises after timer
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_rc_stable <= 1'b0;
            settle_cnt     <= '0;
            freq_active    <= `OSPM_FRC_SEL_RESET;
        end else if (!fast_rc_enable) begin
            fast_rc_stable <= 1'b0;
            settle_cnt     <= '0;
        end else if (wr_frc && avs_writedata[`OSPM_FRC_FREQ_HI:`OSPM_FRC_FREQ_LO] != fast_rc_freq_sel) begin
            fast_rc_stable <= 1'b0;
            settle_cnt     <= '0;
        end else if (!fast_rc_stable) begin
            if (settle_cnt >= `OSPM_CNT_W'(`OSPM_SETTLE_CYC - 1)) begin
                fast_rc_stable <= 1'b1;
                freq_active    <= fast_rc_freq_sel;
            end else begin
                settle_cnt <= settle_cnt + 1'b1;
            end
        end
    end

    // Power mode decode: halt enters idle or sleep from the keep bits
    always_comb begin
        next_mode = mode;
        case (mode)
            OSPM_FAST, OSPM_SLOW: begin
                if (halt_i) begin
                    case ({hs_osc_halt_keep, ls_osc_halt_keep})
                        2'h0:    next_mode = OSPM_SLEEP;
                        2'h1:    next_mode = OSPM_IDLE_SUB;
                        2'h3:    next_mode = OSPM_IDLE_BOTH;
                        default: next_mode = OSPM_IDLE_FAST;
                    endcase
                end else if (sys_clk_sel == `OSPM_SEL_SUB) begin
                    next_mode = OSPM_SLOW;
                end else begin
                    next_mode = OSPM_FAST;
                end
            end
            OSPM_SLEEP, OSPM_IDLE_SUB, OSPM_IDLE_BOTH, OSPM_IDLE_FAST: begin
                // Wake-up source is outside; resume per clock select
                if (wake_i) begin
                    next_mode = (sys_clk_sel == `OSPM_SEL_SUB) ? OSPM_SLOW : OSPM_FAST;
                end
            end
            default: next_mode = OSPM_FAST;
        endcase
    end

    // Mode register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= OSPM_FAST;
        end else begin
            mode <= next_mode;
        end
    end

    // Fast oscillator runs when enabled and the mode allows it
    always_comb begin
        case (mode)
            OSPM_FAST:      fast_run = 1'b1;
            OSPM_SLOW:      fast_run = fast_rc_enable;
            OSPM_IDLE_BOTH: fast_run = fast_rc_enable;
            OSPM_IDLE_FAST: fast_run = fast_rc_enable;
            default:        fast_run = 1'b0;
        endcase
    end

    // Peripheral sub clock stops in sleep and idle_fast_only
    assign sub_run  = (mode != OSPM_SLEEP) && (mode != OSPM_IDLE_FAST);
    assign fast_div = freq_div(freq_active);

    // Fast RC oscillator model: high_clk ticks
    ospm_clk_div u_fast_osc (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .run_i     (fast_run & fast_rc_enable),
        .div_i     (fast_div),
        .tick_o    (fast_tick)
    );

    // Slow RC oscillator model: always running for the watchdog
    ospm_clk_div u_slow_osc (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .run_i     (1'b1),
        .div_i     (sys_div),
        .tick_o    (slow_tick)
    );

    assign sys_div = `OSPM_DIV_W'(`OSPM_CLK_HZ / `OSPM_SLOW_HZ);

    // Prescaler on high_clk gives /2 through /64
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc <= '0;
        end else if (fast_tick) begin
            presc <= presc + 1'b1;
        end
    end

    // Pick CPU tick: high_clk divided by 2^sel or sub_clk
    always_comb begin
        if (sys_clk_sel == `OSPM_SEL_SUB) begin
            sys_tick = slow_tick & sub_run;
        end else if (sys_clk_sel == 3'h0) begin
            sys_tick = fast_tick;
        end else begin
            // Tick when low sel bits of prescaler are all ones
            sys_tick = fast_tick & (&(presc | ~((7'h01 << sys_clk_sel) - 7'h01)));
        end
    end

    // Output enables, registered; CPU clock gated by mode
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_sys_clk_o <= 1'b0;
            cpu_run_o     <= 1'b0;
            high_clk_o    <= 1'b0;
            sub_clk_o     <= 1'b0;
            slow_rc_clk_o <= 1'b0;
            wdt_clk_o     <= 1'b0;
            tbase_clk_o   <= 1'b0;
            mode_o        <= 6'h00;
        end else begin
            // CPU runs only in the running modes; idle keeps the tick only if that idle mode keeps its source
            cpu_run_o     <= (mode == OSPM_FAST) || (mode == OSPM_SLOW);
            case (mode)
                OSPM_FAST, OSPM_SLOW, OSPM_IDLE_BOTH: cpu_sys_clk_o <= sys_tick;
                OSPM_IDLE_SUB:  cpu_sys_clk_o <= (sys_clk_sel == `OSPM_SEL_SUB) & sys_tick;
                OSPM_IDLE_FAST: cpu_sys_clk_o <= (sys_clk_sel != `OSPM_SEL_SUB) & sys_tick;
                default:        cpu_sys_clk_o <= 1'b0;
            endcase
            // High, sub and time base ticks gated by the mode so one in flight dies on entry to a stop mode; slow RC and watchdog ticks are not
            high_clk_o    <= fast_tick & fast_run;
            sub_clk_o     <= slow_tick & sub_run;
            slow_rc_clk_o <= slow_tick;
            wdt_clk_o     <= slow_tick;
            tbase_clk_o   <= sub_run ? slow_tick : 1'b0;
            mode_o        <= mode;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !answered) begin
            case (avs_address)
                `OSPM_OFS_SYS_CLK_CTRL: avs_readdata <= {24'h000000, sys_clk_sel, 3'h0,
                                                         hs_osc_halt_keep, ls_osc_halt_keep};
                `OSPM_OFS_FAST_RC_CTRL: avs_readdata <= {28'h0000000, fast_rc_freq_sel,
                                                         fast_rc_stable, fast_rc_enable};
                `OSPM_OFS_MODE_STATUS:  avs_readdata <= {26'h0000000, mode};
                default:                avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> inc/ospm_consts.svh
`ifndef OSPM_CONSTS_SVH
`define OSPM_CONSTS_SVH

// Register offsets (byte addresses, word aligned)
`define OSPM_OFS_SYS_CLK_CTRL  4'h0
`define OSPM_OFS_FAST_RC_CTRL  4'h4
`define OSPM_OFS_MODE_STATUS   4'h8
`define OSPM_OFS_HALT_CMD      4'hC

// sys_clk_ctrl_reg fields
`define OSPM_SCC_SEL_HI        7
`define OSPM_SCC_SEL_LO        5
`define OSPM_SCC_HS_KEEP       1
`define OSPM_SCC_LS_KEEP       0

// fast_rc_ctrl_reg fields
`define OSPM_FRC_FREQ_HI       3
`define OSPM_FRC_FREQ_LO       2
`define OSPM_FRC_STABLE        1
`define OSPM_FRC_ENABLE        0

// Reset values
`define OSPM_SCC_RESET         8'h00
`define OSPM_FRC_SEL_RESET     2'h0
`define OSPM_FRC_EN_RESET      1'h1

// System clock select codes
`define OSPM_SEL_SUB           3'h7

// Fast RC frequency codes
`define OSPM_FREQ_2M           2'h0
`define OSPM_FREQ_4M           2'h1
`define OSPM_FREQ_8M           2'h2

// Oscillator model: frequencies and timing
`define OSPM_CLK_HZ            25000000
`define OSPM_SLOW_HZ           32000
`define OSPM_F2M_HZ            2000000
`define OSPM_F4M_HZ            4000000
`define OSPM_F8M_HZ            8000000
`define OSPM_SETTLE_US         16
`define OSPM_SETTLE_CYC        ((`OSPM_SETTLE_US * (`OSPM_CLK_HZ / 1000000)))
`define OSPM_DIV_W             10
`define OSPM_CNT_W             12

`endif

// >>> inc/ospm_pkg.sv
package ospm_pkg;

    // Power modes, one-hot
    typedef enum logic [5:0] {
        OSPM_FAST      = 6'h01,
        OSPM_SLOW      = 6'h02,
        OSPM_SLEEP     = 6'h04,
        OSPM_IDLE_SUB  = 6'h08,
        OSPM_IDLE_BOTH = 6'h10,
        OSPM_IDLE_FAST = 6'h20
    } ospm_mode_t;

endpackage

// >>> tb/ospm_ctrl_asserts.sv
// Watches the clock and mode ports of the controller
module ospm_ctrl_asserts (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       halt_i,
    input wire logic       cpu_run_o,
    input wire logic       cpu_sys_clk_o,
    input wire logic       high_clk_o,
    input wire logic       sub_clk_o,
    input wire logic       slow_rc_clk_o,
    input wire logic       wdt_clk_o,
    input wire logic [5:0] mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] slow_gap; // Cycles since the last slow tick
    logic [9:0] wdt_gap;  // Cycles since the last watchdog tick

    // Gap counters; a stuck divider shows as a count reaching 800
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            slow_gap <= 10'h000;
        end else if (slow_rc_clk_o) begin
            slow_gap <= 10'h000;
        end else begin
            slow_gap <= slow_gap + 10'h001;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_gap <= 10'h000;
        end else if (wdt_clk_o) begin
            wdt_gap <= 10'h000;
        end else begin
            wdt_gap <= wdt_gap + 10'h001;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_sleep_gated;
        mode_o == 6'h04 |-> !(cpu_run_o || cpu_sys_clk_o || high_clk_o || sub_clk_o);
    endproperty
    a_sleep_gated: assert property (p_sleep_gated) else $error("clock active in sleep");
    property p_idle_sub;
        mode_o == 6'h08 |-> !high_clk_o && !cpu_run_o;
    endproperty
    a_idle_sub: assert property (p_idle_sub) else $error("fast clock in idle_sub_only");
    property p_idle_fast;
        mode_o == 6'h20 |-> !sub_clk_o && !cpu_run_o;
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("sub clock in idle_fast_only");
    property p_idle_both;
        mode_o == 6'h10 |-> ##[0:800] (sub_clk_o || mode_o != 6'h10);
    endproperty
    a_idle_both: assert property (p_idle_both) else $error("sub clock stopped in idle_both_clk");
    property p_run_mode;
        cpu_run_o |-> (mode_o == 6'h01 || mode_o == 6'h02);
    endproperty
    a_run_mode: assert property (p_run_mode) else $error("cpu on outside running modes");
    property p_halt_stops;
        halt_i && cpu_run_o |-> ##[1:3] !cpu_run_o;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop cpu");
    property p_slow_runs;
        slow_gap < 10'h320;
    endproperty
    a_slow_runs: assert property (p_slow_runs) else $error("slow clock stalled");
    property p_wdt_runs;
        wdt_gap < 10'h320;
    endproperty
    a_wdt_runs: assert property (p_wdt_runs) else $error("watchdog clock stalled");
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer late");
endmodule

bind ospm_ctrl ospm_ctrl_asserts i_ospm_ctrl_asserts (.*);

// >>> tb/tb.sv
// Self-checking bench for the clock and power-mode controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic        halt_i = 1'b0;
    logic        wake_i = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, cpu_run_o, cpu_sys_clk_o, high_clk_o;
    logic        sub_clk_o, slow_rc_clk_o, wdt_clk_o, tbase_clk_o;
    logic [5:0]  mode_o;
    logic [31:0] exp_q[$];                                  // Expected read data, oldest first
    logic [5:0]  mtab[4] = '{6'h04, 6'h08, 6'h20, 6'h10};   // Mode per keep bits {hs, ls}
    logic [2:0]  sel;                                       // Random clock select
    int          n_fail = 0, n_compared = 0;
    int          n_cpu, n_hi, n_sub, n_slow, n_tb;          // Tick counts in a window

    ospm_ctrl i_ospm_ctrl (.*);

    always #20 ref_clk_i = ~ref_clk_i;

    // Compare one value and count it
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One bus cycle; request held until the rising edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic done;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        done = 1'b0;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge ref_clk_i);
            done = (avs_waitrequest === 1'b0);
        end
        if (!done) n_fail++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'h1);
    endtask

    // Counts ticks of each clock except the watchdog clock over n cycles
    task automatic cnt(input int n);
        n_cpu = 0;
        n_hi = 0;
        n_sub = 0;
        n_slow = 0;
        n_tb = 0;
        repeat (n) begin
            @(negedge ref_clk_i);
            n_cpu += cpu_sys_clk_o;
            n_hi += high_clk_o;
            n_sub += sub_clk_o;
            n_slow += slow_rc_clk_o;
            n_tb += tbase_clk_o;
        end
        @(posedge ref_clk_i);
    endtask

    // Tick spacing; the first two gaps are skipped, they may straddle a switch
    task automatic gap(input logic hi, input int e);
        int g;
        for (int k = 0; k < 3; k++) begin
            g = 0;
            do begin
                @(negedge ref_clk_i);
                g++;
            end while ((hi ? high_clk_o : cpu_sys_clk_o) !== 1'b1 && g < 2000);
        end
        check(hi ? "fast period" : "cpu period", g, e);
        @(posedge ref_clk_i);
    endtask

    // Read monitor: takes the oldest note when read data is due
    always @(posedge ref_clk_i) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check("readdata", avs_readdata, exp_q.pop_front());
    end

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog, about four times the expected run
    initial begin
        #2000000;
        n_fail++;
        finish_test;
    end

    initial begin
        void'($urandom(7));
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h1);
        rd(4'h8, 32'h1);
        repeat (400) @(posedge ref_clk_i);
        rd(4'h4, 32'h3);
        wr(4'hC, 8'hFF);
        rd(4'hC, 32'h0);
        bus(1'b1, 4'h0, 32'hE0, 4'h0);
        rd(4'h0, 32'h0);
        gap(1'b1, 12);
        $display("test reset_and_bus done");
        // Every divider code, then the sub clock
        for (int s = 0; s < 8; s++) begin
            wr(4'h0, 8'(s << 5));
            rd(4'h0, 32'(s << 5));
            rd(4'h8, (s == 7) ? 32'h2 : 32'h1);
            gap(1'b0, (s == 7) ? 781 : (12 << s));
        end
        $display("test clock_select done");
        // Frequency codes 1 to 3 each clear stable, then settle
        for (int f = 1; f < 4; f++) begin
            wr(4'h4, 8'((f << 2) | 1));
            rd(4'h4, 32'((f << 2) | 1));
            repeat (400) @(posedge ref_clk_i);
            rd(4'h4, 32'((f << 2) | 3));
            gap(1'b1, (f == 1) ? 6 : (f == 2) ? 3 : 12);
        end
        $display("test fast_freq done");
        // Halt with every keep pair, random clock select
        for (int k = 0; k < 4; k++) begin
            sel = 3'($urandom % 8);
            wr(4'h0, {sel, 3'h0, 2'(k)});
            halt_i <= 1'b1;
            @(posedge ref_clk_i);
            halt_i <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            rd(4'h8, 32'(mtab[k]));
            cnt(800);
            check("cpu_run", cpu_run_o, 32'h0);
            check("cpu tick", n_cpu > 0, (sel == 3'h7) ? k[0] : k[1]);
            check("fast tick", n_hi > 0, k[1]);
            check("sub tick", n_sub > 0, k[0]);
            check("slow tick", n_slow > 0, 32'h1);
            check("time base tick", n_tb > 0, k[0]);
            wake_i <= 1'b1;
            @(posedge ref_clk_i);
            wake_i <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            rd(4'h8, (sel == 3'h7) ? 32'h2 : 32'h1);
        end
        $display("test halt_modes done");
        // Fast oscillator stopped while running on the sub clock
        wr(4'h0, 8'hE0);
        wr(4'h4, 8'h00);
        rd(4'h4, 32'h0);
        cnt(800);
        check("fast off", n_hi, 32'h0);
        check("cpu on sub", n_cpu > 0, 32'h1);
        wr(4'h4, 8'h01);
        repeat (410) @(posedge ref_clk_i);
        rd(4'h4, 32'h3);
        $display("test fast_stop done");
        finish_test;
    end
endmodule
